/* File: common/aux_voltage_monitor_input_sup_pkg.sv */
// Purpose: shared constants for the auxiliary monitor fault supervisor
// Assumes: 10 MHz core clock, linear-11 words from the monitor converter
// Notes:   command codes double as register offsets
package aux_voltage_monitor_input_sup_pkg;
   // command codes
   localparam logic [7:0]  CMD_OV_LIMIT      = 8'hF5;
   localparam logic [7:0]  CMD_UV_LIMIT      = 8'hF6;
   localparam logic [7:0]  CMD_AUX_VOLTAGE_MONITOR_INPUT_READ     = 8'hF7;
   localparam logic [7:0]  CMD_OV_ACTION     = 8'hF8;
   // values after reset
   localparam logic [15:0] OV_LIMIT_RESET    = 16'hC266;
   localparam logic [15:0] UV_LIMIT_RESET    = 16'hB0CC;
   localparam logic [15:0] AUX_VOLTAGE_MONITOR_INPUT_READ_RESET   = 16'h0000;
   localparam logic [7:0]  OV_ACTION_RESET   = 8'hBF;
   // linear-11 field positions
   localparam int          L11_EXP_MSB       = 15;
   localparam int          L11_EXP_LSB       = 11;
   localparam int          L11_MAN_MSB       = 10;
   localparam int          L11_EXP_BIAS      = 16;
   // action field positions
   localparam int          ACT_MODE_MSB      = 7;
   localparam int          ACT_MODE_LSB      = 6;
   localparam int          ACT_RETRY_MSB     = 5;
   localparam int          ACT_RETRY_LSB     = 3;
   localparam int          ACT_DELAY_MSB     = 2;
   localparam int          ACT_DELAY_LSB     = 0;
   // action codes
   localparam logic [1:0]  MODE_IGNORE       = 2'h0;
   localparam logic [1:0]  MODE_SHUTDOWN     = 2'h2;
   localparam logic [1:0]  MODE_HICCUP       = 2'h3;
   localparam logic [2:0]  RETRY_NONE        = 3'h0;
   localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
   // threshold ratios in percent
   localparam int          OV_WARN_PCT       = 90;
   localparam int          UV_WARN_PCT       = 110;
   localparam int          OV_RECOVER_PCT    = 95;
   localparam int          PCT_FULL          = 100;
   // timing
   localparam int          CLK_PERIOD_NS     = 100;
   localparam int          RETRY_UNIT_MS     = 35;
   localparam int          RETRY_UNIT_CYCLES = RETRY_UNIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          TIMER_W           = 19;
   localparam int          WIDE_W            = 56;

   typedef enum logic [2:0] {
      ST_OFF, ST_RUN, ST_LATCHED, ST_WAIT_LOW, ST_DELAY, ST_HICCUP
   } sup_state_t;
endpackage

/* File: rtl/aux_voltage_monitor_input_fault_supervisor.sv */
// Purpose: overvoltage supervision of the auxiliary monitor input
// Assumes: command layer already decoded from the serial bus, same clock
// Notes:   monitor samples arrive as linear-11 words on the core clock
`timescale 1ns/100ps

module aux_voltage_monitor_input_fault_supervisor
   import aux_voltage_monitor_input_sup_pkg::*;
#(
   parameter int RETRY_UNIT = RETRY_UNIT_CYCLES
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic        CMD_WR,
   input  wire logic        CMD_RD,
   input  wire logic [15:0] CMD_WDATA,
   input  wire logic        CLEAR_FAULTS,
   input  wire logic        WRITE_PROTECT,
   input  wire logic [15:0] AUX_VOLTAGE_MONITOR_INPUT_SAMPLE,
   input  wire logic        AUX_VOLTAGE_MONITOR_INPUT_VALID,
   input  wire logic        CONTROL_PIN,
   input  wire logic        OPERATION_ON,
   input  wire logic        BIAS_OK,
   input  wire logic        OTHER_SHUTDOWN,
   output logic      [15:0] CMD_RDATA,
   output logic             CMD_RVALID,
   output logic             OUTPUT_ENABLE,
   output logic             OV_FAULT_STS,
   output logic             OV_WARN,
   output logic             UV_WARN,
   output logic             ALERT_LINE_O,
   output logic             ALERT_LINE_OE
);

   // the unit timer cannot count a zero unit or one wider than its counter
   if (RETRY_UNIT < 1 || RETRY_UNIT >= (1 << TIMER_W)) begin : g_bad_unit
      $error("RETRY_UNIT out of range");
   end

   // limits and samples may carry different exponents, so compare values
   // linear-11 decode
   function automatic logic signed [WIDE_W-1:0] l11_to_fixed(input logic [15:0] w);
      logic signed [WIDE_W-1:0] man;
      logic signed [5:0]        sh;
      man = WIDE_W'(signed'(w[L11_MAN_MSB:0]));
      sh  = 6'(signed'(w[L11_EXP_MSB:L11_EXP_LSB])) + 6'(L11_EXP_BIAS);
      return man <<< sh;
   endfunction

   logic       [15:0] ov_limit;
   logic       [15:0] uv_limit;
   logic       [15:0] aux_voltage_monitor_input_reading;
   logic       [7:0]  ov_action;
   logic       [2:0]  ctl_sync;
   logic              ctl_on;
   sup_state_t        state;
   sup_state_t        next_state;
   logic [TIMER_W-1:0] unit_cnt;
   logic       [2:0]  tick_cnt;

   // register access decode
   wire wr_ok         = CMD_WR && !WRITE_PROTECT;
   wire wr_ov_limit   = wr_ok && (CMD_CODE == CMD_OV_LIMIT);
   wire wr_uv_limit   = wr_ok && (CMD_CODE == CMD_UV_LIMIT);
   wire wr_ov_action  = wr_ok && (CMD_CODE == CMD_OV_ACTION);
   wire [15:0] rd_mux = (CMD_CODE == CMD_OV_LIMIT)  ? ov_limit :
                        (CMD_CODE == CMD_UV_LIMIT)  ? uv_limit :
                        (CMD_CODE == CMD_AUX_VOLTAGE_MONITOR_INPUT_READ) ? aux_voltage_monitor_input_reading :
                        (CMD_CODE == CMD_OV_ACTION) ? {8'h00, ov_action} : 16'h0000;

   // action fields
   wire [1:0] act_mode  = ov_action[ACT_MODE_MSB:ACT_MODE_LSB];
   wire [2:0] act_retry = ov_action[ACT_RETRY_MSB:ACT_RETRY_LSB];
   wire [2:0] act_delay = ov_action[ACT_DELAY_MSB:ACT_DELAY_LSB];

   // scaled comparisons; percentages kept as integer products
   wire signed [WIDE_W-1:0] aux_voltage_monitor_input_fx = l11_to_fixed(aux_voltage_monitor_input_reading);
   wire signed [WIDE_W-1:0] ov_fx   = l11_to_fixed(ov_limit);
   wire signed [WIDE_W-1:0] uv_fx   = l11_to_fixed(uv_limit);
   wire signed [WIDE_W-1:0] aux_voltage_monitor_input_pc = aux_voltage_monitor_input_fx * WIDE_W'(PCT_FULL);
   wire ov_fault_lvl = aux_voltage_monitor_input_fx > ov_fx;
   wire ov_warn_lvl  = aux_voltage_monitor_input_pc > ov_fx * WIDE_W'(OV_WARN_PCT);
   wire uv_warn_lvl  = aux_voltage_monitor_input_pc < uv_fx * WIDE_W'(UV_WARN_PCT);
   wire below_recov  = aux_voltage_monitor_input_pc < ov_fx * WIDE_W'(OV_RECOVER_PCT);

   // any of these stops the converter
   wire run_ok      = ctl_on && OPERATION_ON && BIAS_OK && !OTHER_SHUTDOWN;
   // only responding modes act on a fault
   wire responding  = (act_mode == MODE_SHUTDOWN) || (act_mode == MODE_HICCUP);
   wire fault_hit   = (state == ST_RUN) && run_ok && ov_fault_lvl && responding;
   wire unit_tick   = (unit_cnt == TIMER_W'(RETRY_UNIT - 1));
   wire retry_done  = unit_tick && (tick_cnt == act_delay);

   // control pin from outside; accept a level once stages two and three agree
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctl_sync <= 3'h0;
         ctl_on   <= 1'b0;
      end else begin
         ctl_sync <= {ctl_sync[1:0], CONTROL_PIN};
         if (ctl_sync[2] == ctl_sync[1]) begin
            ctl_on <= ctl_sync[2];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ov_limit  <= OV_LIMIT_RESET;
         uv_limit  <= UV_LIMIT_RESET;
         ov_action <= OV_ACTION_RESET;
      end else begin
         if (wr_ov_limit) ov_limit <= CMD_WDATA;
         if (wr_uv_limit) uv_limit <= CMD_WDATA;
         if (wr_ov_action) ov_action <= CMD_WDATA[7:0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         aux_voltage_monitor_input_reading <= AUX_VOLTAGE_MONITOR_INPUT_READ_RESET;
         CMD_RDATA    <= 16'h0000;
         CMD_RVALID   <= 1'b0;
      end else begin
         if (AUX_VOLTAGE_MONITOR_INPUT_VALID) aux_voltage_monitor_input_reading <= AUX_VOLTAGE_MONITOR_INPUT_SAMPLE;
         CMD_RVALID <= CMD_RD;
         if (CMD_RD) CMD_RDATA <= rd_mux;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (run_ok) next_state = ST_RUN;
         end
         ST_RUN: begin
            if (!run_ok) begin
               next_state = ST_OFF;
            end else if (fault_hit && act_mode == MODE_SHUTDOWN) begin
               // only the continuous code retries; unused codes latch
               next_state = (act_retry == RETRY_FOREVER) ? ST_WAIT_LOW : ST_LATCHED;
            end else if (fault_hit) begin
               next_state = ST_HICCUP;
            end
         end
         ST_LATCHED: begin
            // held until the host clears faults or run_ok drops
            if (!run_ok) next_state = ST_OFF;
            else if (CLEAR_FAULTS) next_state = ST_RUN;
         end
         ST_WAIT_LOW: begin
            // restart only after the monitor falls back
            if (!run_ok) next_state = ST_OFF;
            else if (below_recov) next_state = ST_DELAY;
         end
         ST_DELAY: begin
            // restart with no fresh fault check
            if (!run_ok) next_state = ST_OFF;
            else if (retry_done) next_state = ST_RUN;
         end
         ST_HICCUP: begin
            if (!run_ok) next_state = ST_OFF;
            else if (below_recov) next_state = ST_RUN;
         end
         default: next_state = ST_OFF;
      endcase
   end

   // enable taken from the next state so it drops with the state, not a cycle later
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state         <= ST_OFF;
         OUTPUT_ENABLE <= 1'b0;
      end else begin
         state         <= next_state;
         OUTPUT_ENABLE <= (next_state == ST_RUN);
      end
   end

   // unit timer restarts on entry so the first unit is whole
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         unit_cnt <= '0;
         tick_cnt <= 3'h0;
      end else if (state != ST_DELAY) begin
         unit_cnt <= '0;
         tick_cnt <= 3'h0;
      end else if (unit_tick) begin
         unit_cnt <= '0;
         tick_cnt <= tick_cnt + 3'h1;
      end else begin
         unit_cnt <= unit_cnt + TIMER_W'(1);
      end
   end

   // alert pin is open drain: data held low, the enable does the pulling
   // sticky status and alert; a new fault beats a same-cycle clear
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         OV_FAULT_STS  <= 1'b0;
         ALERT_LINE_OE <= 1'b0;
         ALERT_LINE_O  <= 1'b0;
         OV_WARN       <= 1'b0;
         UV_WARN       <= 1'b0;
      end else begin
         if (fault_hit) begin
            OV_FAULT_STS  <= 1'b1;
            ALERT_LINE_OE <= 1'b1;
         end else if (CLEAR_FAULTS) begin
            OV_FAULT_STS  <= 1'b0;
            ALERT_LINE_OE <= 1'b0;
         end
         OV_WARN <= ov_warn_lvl;
         UV_WARN <= uv_warn_lvl;
      end
   end

   logic [TIMER_W+2:0] delay_len;
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         delay_len <= '0;
      end else if (state != ST_DELAY) begin
         delay_len <= '0;
      end else begin
         delay_len <= delay_len + (TIMER_W+3)'(1);
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   a_ov_warn_track: assert property (1'b1 |=> OV_WARN == $past(ov_warn_lvl))
      else $error("overvoltage warning not tracking 90 percent level");
   a_uv_warn_track: assert property (1'b1 |=> UV_WARN == $past(uv_warn_lvl))
      else $error("undervoltage warning not tracking 110 percent level");
   a_ov_limit_hold: assert property (!$stable(ov_limit) |-> $past(wr_ov_limit))
      else $error("overvoltage limit changed without permitted write");
   a_uv_limit_hold: assert property (!$stable(uv_limit) |-> $past(wr_uv_limit))
      else $error("undervoltage limit changed without permitted write");
   a_action_hold: assert property (!$stable(ov_action) |-> $past(wr_ov_action))
      else $error("action register changed without permitted write");
   a_read_aux_voltage_monitor_input: assert property (CMD_RD && CMD_CODE == CMD_AUX_VOLTAGE_MONITOR_INPUT_READ |=>
                                 CMD_RVALID && CMD_RDATA == $past(aux_voltage_monitor_input_reading))
      else $error("monitor reading not returned");
   a_ignore_mode: assert property (state == ST_RUN && run_ok && !responding |=> state == ST_RUN)
      else $error("fault acted on while ignored");
   a_shut_now: assert property (fault_hit && act_mode == MODE_SHUTDOWN |=> !OUTPUT_ENABLE)
      else $error("output not disabled on fault");
   a_hiccup_hold: assert property (state == ST_HICCUP && run_ok && !below_recov |=>
                                   state == ST_HICCUP && !OUTPUT_ENABLE)
      else $error("hiccup resumed above recovery level");
   a_fault_sticky: assert property (fault_hit ##1 !CLEAR_FAULTS[*2] |-> OV_FAULT_STS && ALERT_LINE_OE)
      else $error("status or alert lost before clear");
   a_latched_hold: assert property (state == ST_LATCHED && run_ok && !CLEAR_FAULTS |=> state == ST_LATCHED)
      else $error("latched shutdown left without clear");
   a_retry_restart: assert property (state == ST_DELAY && run_ok && retry_done |=>
                                     state == ST_RUN && OUTPUT_ENABLE)
      else $error("retry did not restart");
   a_wait_low: assert property (state == ST_WAIT_LOW && run_ok && !below_recov |=> state == ST_WAIT_LOW)
      else $error("restart begun above recovery level");
   a_retry_space: assert property (state == ST_DELAY && !unit_tick |=> state != ST_RUN)
      else $error("restart before delay unit ended");
   a_tick_bound: assert property (state == ST_DELAY |-> tick_cnt <= act_delay)
      else $error("delay count passed programmed value");

   // register access
   a_write_lands: assert property (wr_ov_limit |=> ov_limit == $past(CMD_WDATA))
      else $error("overvoltage limit write lost");
   a_uv_write_lands: assert property (wr_uv_limit |=> uv_limit == $past(CMD_WDATA))
      else $error("undervoltage limit write lost");
   a_action_write: assert property (wr_ov_action |=> ov_action == $past(CMD_WDATA[7:0]))
      else $error("action register write lost");
   a_protect_write: assert property (WRITE_PROTECT |=>
                                     $stable(ov_limit) && $stable(uv_limit) && $stable(ov_action))
      else $error("protected register changed");
   a_read_action: assert property (CMD_RD && CMD_CODE == CMD_OV_ACTION |=>
                                   CMD_RDATA == {8'h00, $past(ov_action)})
      else $error("action register read wrong");
   a_read_pulse: assert property (!CMD_RD |=> !CMD_RVALID)
      else $error("read answer without request");
   a_reading_ro: assert property (!$stable(aux_voltage_monitor_input_reading) |-> $past(AUX_VOLTAGE_MONITOR_INPUT_VALID))
      else $error("reading changed without a sample");

   // warnings against fault levels; a negative limit has no meaningful percentage
   a_fault_warns: assert property (ov_fault_lvl && !ov_fx[WIDE_W-1] |=> OV_WARN)
      else $error("overvoltage fault level without warning");
   a_uv_fault_warns: assert property (aux_voltage_monitor_input_fx < uv_fx && !uv_fx[WIDE_W-1] |=> UV_WARN)
      else $error("undervoltage fault level without warning");

   // fault entry and response
   a_alert_drive: assert property (fault_hit |=> OV_FAULT_STS && ALERT_LINE_OE && !ALERT_LINE_O)
      else $error("fault not reported on status and alert");
   a_clear_release: assert property (CLEAR_FAULTS && !fault_hit |=> !OV_FAULT_STS && !ALERT_LINE_OE)
      else $error("clear faults did not release status");
   a_latch_entry: assert property (fault_hit && act_mode == MODE_SHUTDOWN &&
                                   act_retry != RETRY_FOREVER |=> state == ST_LATCHED)
      else $error("no-retry fault not latched");
   a_wait_on_fault: assert property (fault_hit && act_mode == MODE_SHUTDOWN &&
                                     act_retry == RETRY_FOREVER |=> state == ST_WAIT_LOW)
      else $error("retry fault did not wait for low monitor");
   a_hiccup_entry: assert property (fault_hit && act_mode == MODE_HICCUP |=>
                                    state == ST_HICCUP && !OUTPUT_ENABLE)
      else $error("hiccup fault did not disable output");
   a_hiccup_resume: assert property (state == ST_HICCUP && run_ok && below_recov |=> OUTPUT_ENABLE)
      else $error("hiccup did not resume below recovery level");

   // retry sequence and turn-off
   a_delay_entry: assert property (state == ST_WAIT_LOW && run_ok && below_recov |=> state == ST_DELAY)
      else $error("delay not started below recovery level");
   a_retry_length: assert property (state == ST_DELAY && next_state == ST_RUN |->
                                    delay_len == (TIMER_W+3)'((int'(act_delay) + 1) * RETRY_UNIT - 1))
      else $error("restart spacing differs from programmed delay");
   a_run_loss_off: assert property (!run_ok |=> !OUTPUT_ENABLE)
      else $error("output left on after turn-off");
   a_status_kept: assert property (!run_ok && !CLEAR_FAULTS |=> $stable(OV_FAULT_STS))
      else $error("status changed by turn-off");

   c_shutdown_retry: cover property (state == ST_DELAY ##1 state == ST_RUN);
   c_hiccup_resume:  cover property (state == ST_HICCUP ##1 state == ST_RUN);
   c_latched_clear:  cover property (state == ST_LATCHED && CLEAR_FAULTS);
   c_set_vs_clear:   cover property (fault_hit && CLEAR_FAULTS);
   c_ignored_fault:  cover property (state == ST_RUN && ov_fault_lvl && !responding);

endmodule // aux_voltage_monitor_input_fault_supervisor

/* File: test/aux_voltage_monitor_input_host_model.sv */
// Purpose: host side of the command port, issuing reads and writes
// Assumes: strobes launched just after the rising edge, one cycle long
// Notes:   write data is scrambled once the strobe is gone
`timescale 1ns/100ps
module aux_voltage_monitor_input_host_model (
   input  wire logic        CORE_CLK,
   input  wire logic [15:0] CMD_RDATA,
   input  wire logic        CMD_RVALID,
   output logic      [7:0]  CMD_CODE,
   output logic             CMD_WR,
   output logic             CMD_RD,
   output logic      [15:0] CMD_WDATA
);
   initial begin
      CMD_CODE = 8'h00;
      CMD_WR = 1'b0;
      CMD_RD = 1'b0;
      CMD_WDATA = 16'h0000;
   end

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge CORE_CLK);
      CMD_CODE <= c;
      CMD_WDATA <= d;
      CMD_WR <= 1'b1;
      @(posedge CORE_CLK);
      CMD_WR <= 1'b0;
      CMD_WDATA <= ~d;
   endtask

   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
      int i;
      @(posedge CORE_CLK);
      CMD_CODE <= c;
      CMD_RD <= 1'b1;
      @(posedge CORE_CLK);
      CMD_RD <= 1'b0;
      ok = 1'b0;
      d = 16'h0000;
      // the answer stands for one cycle after the strobe edge, so look before the next edge
      for (i = 0; i < 4 && !ok; i++) begin
         #1;
         if (CMD_RVALID === 1'b1) begin
            ok = 1'b1;
            d = CMD_RDATA;
         end
         if (!ok) @(posedge CORE_CLK);
      end
   endtask
endmodule // aux_voltage_monitor_input_host_model

/* File: test/aux_voltage_monitor_input_fault_supervisor_test.sv */
// Purpose: self-checking bench for the monitor fault supervisor
// Assumes: shortened retry unit so delays stay at most 160 cycles
// Notes:   samples use exponent -8 unless noted
`timescale 1ns/100ps
module aux_voltage_monitor_input_fault_supervisor_test;
   import aux_voltage_monitor_input_sup_pkg::*;
   localparam int UNIT = 20;
   logic CORE_CLK, RST_B, CLEAR_FAULTS, WRITE_PROTECT, AUX_VOLTAGE_MONITOR_INPUT_VALID;
   logic [15:0] AUX_VOLTAGE_MONITOR_INPUT_SAMPLE, CMD_WDATA, CMD_RDATA;
   logic [7:0]  CMD_CODE;
   logic [3:0]  run;
   logic CMD_WR, CMD_RD, CMD_RVALID, OUTPUT_ENABLE, OV_FAULT_STS, OV_WARN, UV_WARN, ALERT_LINE_O, ALERT_LINE_OE;
   int n_mismatch, samples_checked, n, d;

   aux_voltage_monitor_input_host_model i_aux_voltage_monitor_input_host_model (.CORE_CLK(CORE_CLK), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
      .CMD_CODE(CMD_CODE), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_WDATA(CMD_WDATA));
   aux_voltage_monitor_input_fault_supervisor #(.RETRY_UNIT(UNIT)) i_aux_voltage_monitor_input_fault_supervisor (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
      .CMD_CODE(CMD_CODE), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_WDATA(CMD_WDATA),
      .CLEAR_FAULTS(CLEAR_FAULTS), .WRITE_PROTECT(WRITE_PROTECT), .AUX_VOLTAGE_MONITOR_INPUT_SAMPLE(AUX_VOLTAGE_MONITOR_INPUT_SAMPLE),
      .AUX_VOLTAGE_MONITOR_INPUT_VALID(AUX_VOLTAGE_MONITOR_INPUT_VALID), .CONTROL_PIN(run[0]), .OPERATION_ON(run[1]), .BIAS_OK(run[2]),
      .OTHER_SHUTDOWN(~run[3]), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
      .OUTPUT_ENABLE(OUTPUT_ENABLE), .OV_FAULT_STS(OV_FAULT_STS), .OV_WARN(OV_WARN), .UV_WARN(UV_WARN),
      .ALERT_LINE_O(ALERT_LINE_O), .ALERT_LINE_OE(ALERT_LINE_OE));

   always #50 CORE_CLK = ~CORE_CLK;

   task automatic results();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] v;
      logic ok;
      i_aux_voltage_monitor_input_host_model.rd(c, v, ok);
      check(ok && v === exp, "register read");
      if (!ok) results();
   endtask

   // outputs settled two edges after the capture edge
   task automatic sample(input logic [15:0] s);
      @(posedge CORE_CLK);
      AUX_VOLTAGE_MONITOR_INPUT_SAMPLE <= s;
      AUX_VOLTAGE_MONITOR_INPUT_VALID <= 1'b1;
      @(posedge CORE_CLK);
      AUX_VOLTAGE_MONITOR_INPUT_VALID <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      #1;
   endtask

   task automatic wait_oe(input logic v, input int lim, output int k);
      k = 0;
      while (OUTPUT_ENABLE !== v && k < lim) begin
         @(posedge CORE_CLK);
         #1;
         k++;
      end
      check(k < lim, "output enable wait ran out");
      if (k >= lim) results();
   endtask

   task automatic clear_faults();
      @(posedge CORE_CLK);
      CLEAR_FAULTS <= 1'b1;
      @(posedge CORE_CLK);
      CLEAR_FAULTS <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      #1;
      check(OV_FAULT_STS === 1'b0 && ALERT_LINE_OE === 1'b0, "status not cleared");
   endtask

   task automatic t_reset_and_protect();
      rdchk(CMD_OV_LIMIT, 16'hC266);
      rdchk(CMD_UV_LIMIT, 16'hB0CC);
      rdchk(CMD_OV_ACTION, 16'h00BF);
      rdchk(CMD_AUX_VOLTAGE_MONITOR_INPUT_READ, 16'h0000);
      rdchk(8'h00, 16'h0000);
      @(posedge CORE_CLK);
      WRITE_PROTECT <= 1'b1;
      i_aux_voltage_monitor_input_host_model.wr(CMD_OV_LIMIT, 16'hC300);
      i_aux_voltage_monitor_input_host_model.wr(CMD_OV_ACTION, 16'h0000);
      @(posedge CORE_CLK);
      WRITE_PROTECT <= 1'b0;
      rdchk(CMD_OV_LIMIT, 16'hC266);
      rdchk(CMD_OV_ACTION, 16'h00BF);
      i_aux_voltage_monitor_input_host_model.wr(CMD_AUX_VOLTAGE_MONITOR_INPUT_READ, 16'h1234);
      rdchk(CMD_AUX_VOLTAGE_MONITOR_INPUT_READ, 16'h0000);
      i_aux_voltage_monitor_input_host_model.wr(CMD_UV_LIMIT, 16'hB0D0);
      rdchk(CMD_UV_LIMIT, 16'hB0D0);
      i_aux_voltage_monitor_input_host_model.wr(CMD_UV_LIMIT, 16'hB0CC);
   endtask

   task automatic t_warnings();
      sample(16'hC229);
      check(OV_WARN === 1'b1, "ov warn at 553");
      rdchk(CMD_AUX_VOLTAGE_MONITOR_INPUT_READ, 16'hC229);
      sample(16'hC228);
      check(OV_WARN === 1'b0, "ov warn at 552");
      sample(16'hC038);
      check(UV_WARN === 1'b1, "uv warn at 56");
      sample(16'hC039);
      check(UV_WARN === 1'b0, "uv warn at 57");
   endtask

   task automatic t_ignore_and_latch();
      i_aux_voltage_monitor_input_host_model.wr(CMD_OV_ACTION, 16'h0000);
      sample(16'hC2BC);
      check(OUTPUT_ENABLE === 1'b1 && OV_FAULT_STS === 1'b0 && ALERT_LINE_OE === 1'b0, "ignored fault");
      // back under the limit first, or the new mode trips on the stale reading
      sample(16'hC1F4);
      check(OUTPUT_ENABLE === 1'b1 && OV_WARN === 1'b0, "ignored fault left a trace");
      i_aux_voltage_monitor_input_host_model.wr(CMD_OV_ACTION, 16'h0080);
      // exponent -7: 307 sits exactly at the limit, 308 just over
      sample(16'hC933);
      check(OUTPUT_ENABLE === 1'b1, "fault below limit");
      sample(16'hC934);
      check(OUTPUT_ENABLE === 1'b0 && OV_FAULT_STS === 1'b1, "no shutdown");
      check(ALERT_LINE_OE === 1'b1 && ALERT_LINE_O === 1'b0, "alert not pulled");
      sample(16'hC1F4);
      repeat (50) @(posedge CORE_CLK);
      #1;
      check(OUTPUT_ENABLE === 1'b0, "restart without retry");
      clear_faults();
      wait_oe(1'b1, 10, n);
   endtask

   task automatic t_hiccup();
      i_aux_voltage_monitor_input_host_model.wr(CMD_OV_ACTION, 16'h00C0);
      sample(16'hC2BC);
      check(OUTPUT_ENABLE === 1'b0, "hiccup not off");
      sample(16'hC248);
      repeat (10) @(posedge CORE_CLK);
      #1;
      check(OUTPUT_ENABLE === 1'b0, "resumed above 95 percent");
      sample(16'hC247);
      wait_oe(1'b1, 3, n);
      check(OV_FAULT_STS === 1'b1, "status not sticky");
      clear_faults();
   endtask

   task automatic t_retry();
      for (d = 0; d < 8; d += 7) begin
         i_aux_voltage_monitor_input_host_model.wr(CMD_OV_ACTION, 16'h00B8 | d[15:0]);
         sample(16'hC2BC);
         check(OUTPUT_ENABLE === 1'b0, "retry mode not off");
         repeat (100) @(posedge CORE_CLK);
         #1;
         check(OUTPUT_ENABLE === 1'b0, "restart while high");
         sample(16'hC1F4);
         wait_oe(1'b1, 400, n);
         check(n >= (d + 1) * UNIT - 4 && n <= (d + 1) * UNIT + 2, "retry spacing");
      end
      clear_faults();
   endtask

   task automatic t_run_off();
      int k;
      for (k = 0; k < 4; k++) begin
         @(posedge CORE_CLK);
         run[k] <= 1'b0;
         wait_oe(1'b0, 8, n);
         check(OV_FAULT_STS === 1'b0, "status moved on turn-off");
         @(posedge CORE_CLK);
         run[k] <= 1'b1;
         wait_oe(1'b1, 10, n);
      end
   endtask

   initial begin
      CORE_CLK = 1'b0;
      RST_B = 1'b0;
      CLEAR_FAULTS = 1'b0;
      WRITE_PROTECT = 1'b0;
      AUX_VOLTAGE_MONITOR_INPUT_VALID = 1'b0;
      AUX_VOLTAGE_MONITOR_INPUT_SAMPLE = 16'hC100;
      run = 4'hF;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (4) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      wait_oe(1'b1, 20, n);
      t_reset_and_protect();
      t_warnings();
      t_ignore_and_latch();
      t_hiccup();
      t_retry();
      t_run_off();
      results();
   end
endmodule // aux_voltage_monitor_input_fault_supervisor_test
